/* bench/lpc_dev_model.sv */
// Behavioural memory device: answers READ with data and per-lane strobes.
// Assumes the command pins are sampled on sys_clk while the clock runs.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defines.svh"
module lpc_dev_model (
  input  wire logic        sys_clk,
  input  wire logic        ck_run,
  input  wire logic        cl3,
  input  wire logic [1:0]  lane_en,
  input  wire logic [3:0]  pins,
  input  wire logic [12:0] addr,
  output logic [15:0]      dq,
  output logic [1:0]       dqs
);
  logic [6:0]  sh_r   = '0;
  logic [15:0] word_r = '0;
  logic        tog_r  = 1'b0;
  logic        live;
  always @(posedge sys_clk) begin
    if (ck_run) begin
      sh_r <= {sh_r[5:0], pins == `LPC_PIN_RD};
      if (pins == `LPC_PIN_RD) begin
        word_r <= {3'h5, addr};
      end
    end
    tog_r <= !tog_r;
  end
  // Data from CL-1 clocks after the READ edge, held five clocks
  assign live = cl3 ? |sh_r[6:2] : |sh_r[5:1];
  // Released bus toggles so stale data never looks valid
  assign #1 dq  = live ? word_r : {16{tog_r}};
  assign #1 dqs = live ? lane_en : 2'h0;
endmodule : lpc_dev_model
`default_nettype wire

/* bench/lpc_host_asserts.sv */
// Checker bound to lpc_host: command spacing, read latency, pin levels.
// Assumes one clock, sys_clk, and one reset, rst.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defines.svh"
module lpc_host_asserts
  import lpc_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       cfg_cl3,
  input wire logic       cmd_valid,
  input wire lpc_cmd_e   cmd_code,
  input wire logic       cmd_ap,
  input wire logic       cmd_ready,
  input wire logic       freq_change_ok,
  input wire logic       rd_valid,
  input wire logic       ddr_ck_run,
  input wire logic       ddr_cke,
  input wire logic       ddr_cs_n,
  input wire logic       ddr_ras_n,
  input wire logic       ddr_cas_n,
  input wire logic       ddr_we_n,
  input wire logic [1:0] dqs_oe
);
  logic       take;
  lpc_cmd_e   tc;
  logic [3:0] pin_w;
  // Untaken offers read as NOP
  assign take  = cmd_valid && cmd_ready;
  assign tc    = take ? cmd_code : LPC_NOP;
  assign pin_w = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_act_space: assert property (tc == LPC_ACT |=> tc != LPC_ACT)
    else $error("ACT taken too soon after ACT");
  a_wr_to_rd: assert property (tc == LPC_WR |=> (tc != LPC_RD) [*4])
    else $error("READ taken too soon after WRITE");
  a_wr_to_pre: assert property (tc == LPC_WR |=> (tc != LPC_PRE) [*5])
    else $error("PRECHARGE inside write recovery");
  a_wrap_to_act: assert property (tc == LPC_WR && cmd_ap |=> (tc != LPC_ACT) [*8])
    else $error("ACT inside auto precharge write delay");
  // NOP stays legal inside every wait, so only real commands count
  a_srsel_hold: assert property (tc == LPC_SRSEL |=> tc == LPC_NOP)
    else $error("command too soon after status select");
  a_pdx_hold: assert property (tc == LPC_PDX |=> tc == LPC_NOP)
    else $error("command too soon after power-down exit");
  a_srx_hold: assert property (tc == LPC_SRX |=> (tc == LPC_NOP) [*8])
    else $error("command too soon after self refresh exit");
  // Pulse is launched on the fifth or sixth edge, so sampled one edge later
  a_rd_lat_two: assert property (tc == LPC_RD && !cfg_cl3 |-> ##6 rd_valid)
    else $error("read data late or missing at latency 2");
  a_rd_lat_three: assert property (tc == LPC_RD && cfg_cl3 |-> ##7 rd_valid)
    else $error("read data late or missing at latency 3");
  // Flag is registered, so one cycle of lag is allowed
  a_freq_gate: assert property (freq_change_ok |->
    !ddr_ck_run || !ddr_cke || $past(!ddr_ck_run || !ddr_cke))
    else $error("frequency change allowed while running");
  a_wr_strobe: assert property (pin_w == `LPC_PIN_WR |-> dqs_oe == 2'h3)
    else $error("write strobe not driven with WRITE");

  c_status_read: cover property (tc == LPC_SRSEL ##3 tc == LPC_RD);
  c_read_cl3: cover property (tc == LPC_RD && cfg_cl3 ##7 rd_valid);
  c_sref_exit: cover property (tc == LPC_SRX);
endmodule : lpc_host_asserts

bind lpc_host lpc_host_asserts u_lpc_host_asserts (
  .sys_clk, .rst, .cfg_cl3, .cmd_valid, .cmd_code, .cmd_ap, .cmd_ready, .freq_change_ok,
  .rd_valid, .ddr_ck_run, .ddr_cke, .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n, .dqs_oe
);
`default_nettype wire

/* bench/test_lpc_host.sv */
// Self-checking bench for lpc_host against a behavioural device.
// Assumes defines, package, design, checker and model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defines.svh"
module test_lpc_host;
  import lpc_pkg::*;
  logic        sys_clk = 0, rst = 1, ce = 1, cfg_cl3 = 0, cmd_valid = 0, cmd_ap = 0;
  lpc_cmd_e    cmd_code = LPC_NOP;
  logic [1:0]  cmd_bank = '0, lane_en = 2'h3, dqs_o, dqs_oe, dqs_i, ddr_ba, rd_lane_ok;
  logic [12:0] cmd_addr = '0, ddr_addr;
  logic [15:0] dq_i, rd_data;
  logic        cmd_ready, refresh_due, freq_change_ok, rd_valid, ddr_ck_run, ddr_cke;
  logic        ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n;
  int          n_errors = 0, tests_run = 0, g, cyc = 0;

  lpc_host u_lpc_host (.sys_clk, .rst, .ce, .cfg_cl3, .cmd_valid, .cmd_code, .cmd_bank,
    .cmd_ap, .cmd_addr, .cmd_ready, .refresh_due, .freq_change_ok, .rd_valid, .rd_data,
    .rd_lane_ok, .ddr_ck_run, .ddr_cke, .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n,
    .ddr_ba, .ddr_addr, .dqs_o, .dqs_oe, .dqs_i, .dq_i);
  lpc_dev_model u_lpc_dev_model (.sys_clk, .ck_run(ddr_ck_run), .cl3(cfg_cl3), .lane_en,
    .pins({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n}), .addr(ddr_addr), .dq(dq_i),
    .dqs(dqs_i));

  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc++;

  task automatic wrap_up;
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input int got, input int exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk16
  // Offer a command; n is cycles since the previous take when called back to back
  task automatic issue(input lpc_cmd_e c, input logic [1:0] b, input logic ap,
                       input logic [12:0] a, output int n);
    n = 1;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_bank = b;
    cmd_ap = ap;
    cmd_addr = a;
    #1;
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
  endtask : issue
  task automatic idle;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_code = LPC_NOP;
  endtask : idle
  task automatic t_act;
    issue(LPC_ACT, 2'h0, 1'b0, 13'h0000, g);
    issue(LPC_ACT, 2'h1, 1'b0, 13'h0000, g);
    chk(g, `LPC_TRRD_CYC + 1);
    #1;
    chk16(16'(ddr_ba), 16'h0001);
  endtask : t_act
  task automatic t_read(input logic cl, input logic [1:0] lanes, input logic [12:0] a);
    int k;
    logic [15:0] m;
    idle();
    // Latency must not change while an earlier read is in flight
    repeat (3) @(negedge sys_clk);
    cfg_cl3 = cl;
    lane_en = lanes;
    issue(LPC_RD, 2'h0, 1'b0, a, g);
    idle();
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (rd_valid !== 1'b1 && k < 20);
    chk(k, cl ? 6 : 5);
    m = {{8{lanes[1]}}, {8{lanes[0]}}};
    chk16(rd_data & m, {3'h5, a} & m);
    chk16(16'(rd_lane_ok), 16'(lanes));
  endtask : t_read
  task automatic t_wr;
    issue(LPC_WR, 2'h0, 1'b0, 13'h0000, g);
    #1;
    chk16(16'(dqs_oe), 16'h0003);
    issue(LPC_RD, 2'h0, 1'b0, 13'h0000, g);
    chk(g, `LPC_WBURST_CYC + `LPC_TWTR_CYC + 1);
    issue(LPC_WR, 2'h0, 1'b0, 13'h0000, g);
    issue(LPC_PRE, 2'h0, 1'b0, 13'h0000, g);
    chk(g, `LPC_WBURST_CYC + `LPC_TWR_CYC + 1);
    issue(LPC_ACT, 2'h0, 1'b0, 13'h0000, g);
    issue(LPC_WR, 2'h0, 1'b1, 13'h0000, g);
    issue(LPC_ACT, 2'h0, 1'b0, 13'h0000, g);
    chk(g, `LPC_WBURST_CYC + `LPC_TDAL_CYC + 1);
  endtask : t_wr
  task automatic t_status;
    issue(LPC_SRSEL, 2'h0, 1'b0, 13'h0000, g);
    issue(LPC_RD, 2'h0, 1'b0, 13'h0000, g);
    chk(g, `LPC_STATUS_SELECT_TO_READ_CYC + 1);
    // NOP is always legal, so a mode write probes the gate
    issue(LPC_MRS, 2'h0, 1'b0, 13'h0000, g);
    chk(g, (cfg_cl3 ? `LPC_CL3 : `LPC_CL2) + 2);
  endtask : t_status
  task automatic t_modes;
    issue(LPC_PDE, 2'h0, 1'b0, 13'h0000, g);
    idle();
    repeat (3) @(posedge sys_clk);
    #1;
    chk16(16'(freq_change_ok), 16'h0001);
    issue(LPC_PDX, 2'h0, 1'b0, 13'h0000, g);
    issue(LPC_MRS, 2'h0, 1'b0, 13'h0000, g);
    chk(g, `LPC_TXP_CYC + 1);
    issue(LPC_CKSTOP, 2'h0, 1'b0, 13'h0000, g);
    idle();
    repeat (3) @(posedge sys_clk);
    #1;
    chk16(16'({ddr_ck_run, freq_change_ok}), 16'h0001);
    issue(LPC_CKRUN, 2'h0, 1'b0, 13'h0000, g);
    issue(LPC_SRE, 2'h0, 1'b0, 13'h0000, g);
    idle();
    repeat (4) @(posedge sys_clk);
    #1;
    chk16(16'(ddr_cke), 16'h0000);
    issue(LPC_SRX, 2'h0, 1'b0, 13'h0000, g);
    issue(LPC_MRS, 2'h0, 1'b0, 13'h0000, g);
    chk(g, `LPC_TXSR_CYC + 1);
    chk16(16'(ddr_ck_run), 16'h0001);
    idle();
  endtask : t_modes
  task automatic t_refresh;
    int c0;
    while (refresh_due !== 1'b1 && cyc < 4000) @(negedge sys_clk);
    issue(LPC_REF, 2'h0, 1'b0, 13'h0000, g);
    idle();
    // Count from the edge that took the refresh
    c0 = cyc;
    #1;
    chk16(16'(refresh_due), 16'h0000);
    while (refresh_due !== 1'b1 && cyc < c0 + 2000) @(negedge sys_clk);
    chk(cyc - c0, `LPC_TREFI_CYC);
  endtask : t_refresh

  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_act();
    t_read(1'b0, 2'h3, 13'h00A5);
    t_read(1'b1, 2'h1, 13'h1F3C);
    t_read(1'b0, 2'h2, 13'h0B6E);
    t_wr();
    t_status();
    t_modes();
    t_refresh();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    wrap_up();
  end
endmodule : test_lpc_host
`default_nettype wire

/* hdl/lpc_defines.svh */
// Timing counts and pin codes for the low-power DDR command timing controller.
// Assumes a 200 MHz controller clock that also clocks the memory device.
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH

`define LPC_CLK_PS        5000
`define LPC_CEIL(ps)      (((ps) + `LPC_CLK_PS - 1) / `LPC_CLK_PS)
`define LPC_FLOOR(ps)     ((ps) / `LPC_CLK_PS)

// Least times, rounded up to whole clocks
`define LPC_TRRD_PS       10000
`define LPC_TRRD_CYC      `LPC_CEIL(`LPC_TRRD_PS)
`define LPC_TWR_PS        15000
`define LPC_TWR_CYC       `LPC_CEIL(`LPC_TWR_PS)
`define LPC_TRP_PS        15000
`define LPC_TRP_CYC       `LPC_CEIL(`LPC_TRP_PS)
`define LPC_TDAL_CYC      (`LPC_TWR_CYC + `LPC_TRP_CYC)
`define LPC_TXSR_PS       120000
`define LPC_TXSR_CYC      `LPC_CEIL(`LPC_TXSR_PS)
`define LPC_TRFC_PS       72000
`define LPC_TRFC_CYC      `LPC_CEIL(`LPC_TRFC_PS)
// Longest time, rounded down: 64 ms over 8192 rows
`define LPC_TREFI_PS      7812500
`define LPC_TREFI_CYC     `LPC_FLOOR(`LPC_TREFI_PS)

// Clock-counted figures
`define LPC_STATUS_SELECT_TO_READ_CYC      2
`define LPC_TWTR_CYC      2
`define LPC_TXP_CYC       2
`define LPC_TMRD_CYC      2
`define LPC_TCKE_CYC      2
`define LPC_XSR_TOGGLES   2
`define LPC_WBURST_CYC    3
`define LPC_CL2           2
`define LPC_CL3           3
`define LPC_SYNC_STAGES   2

// Pin code {cs_n, ras_n, cas_n, we_n}
`define LPC_PIN_NOP       4'h7
`define LPC_PIN_ACT       4'h3
`define LPC_PIN_RD        4'h5
`define LPC_PIN_WR        4'h4
`define LPC_PIN_PRE       4'h2
`define LPC_PIN_REF       4'h1
`define LPC_PIN_MRS       4'h0

`endif

/* hdl/lpc_host.sv */
// Command timing gate for a low-power DDR device, driving its command pins.
// Assumes sys_clk also clocks the device; dq/dqs inputs arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defines.svh"

module lpc_host
  import lpc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        cfg_cl3,
  input  wire logic        cmd_valid,
  input  wire lpc_cmd_e    cmd_code,
  input  wire logic [1:0]  cmd_bank,
  input  wire logic        cmd_ap,
  input  wire logic [12:0] cmd_addr,
  output logic             cmd_ready,
  output logic             refresh_due,
  output logic             freq_change_ok,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  output logic [1:0]       rd_lane_ok,
  output logic             ddr_ck_run,
  output logic             ddr_cke,
  output logic             ddr_cs_n,
  output logic             ddr_ras_n,
  output logic             ddr_cas_n,
  output logic             ddr_we_n,
  output logic [1:0]       ddr_ba,
  output logic [12:0]      ddr_addr,
  output logic [1:0]       dqs_o,
  output logic [1:0]       dqs_oe,
  input  wire logic [1:0]  dqs_i,
  input  wire logic [15:0] dq_i
);

  lpc_state_e  st_r,     st_nxt;
  lpc_cnt_t    gate_r,   gate_nxt;
  lpc_cnt_t    rrd_r,    rrd_nxt;
  lpc_cnt_t    wtr_r,    wtr_nxt;
  lpc_cnt_t    srr_r,    srr_nxt;
  lpc_cnt_t    ckel_r,   ckel_nxt;
  lpc_cnt_t    tog_r,    tog_nxt;
  lpc_cnt_t    wdqs_r,   wdqs_nxt;
  lpc_cnt_t    wrec_r    [4];
  lpc_cnt_t    wrec_nxt  [4];
  lpc_cnt_t    bblk_r    [4];
  lpc_cnt_t    bblk_nxt  [4];
  logic [10:0] refi_r,   refi_nxt;
  logic        due_r,    due_nxt;
  logic        run_r,    run_nxt;
  logic        cke_r,    cke_nxt;
  logic        fok_r,    fok_nxt;
  logic [3:0]  pin_r,    pin_nxt;
  logic [1:0]  ba_r,     ba_nxt;
  logic [12:0] addr_r,   addr_nxt;
  logic [1:0]  dqso_r,   dqso_nxt;
  logic [1:0]  dqsoe_r,  dqsoe_nxt;
  logic [7:0]  pipe_r,   pipe_nxt;
  logic        rdv_r,    rdv_nxt;
  logic [15:0] rdd_r,    rdd_nxt;
  logic [1:0]  lane_r,   lane_nxt;
  logic [15:0] dq_s1,    dq_s2;
  logic [1:0]  dqs_s1,   dqs_s2;
  logic        legal;
  logic        go;
  logic        wr_idle;
  logic        run_ok;
  logic        rd_hit;

  function automatic lpc_cnt_t dec(input lpc_cnt_t x);
    dec = (x == '0) ? '0 : x - 8'h01;
  endfunction : dec

  // Two-stage capture of the asynchronous read bus
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dq_s1  <= '0;
      dq_s2  <= '0;
      dqs_s1 <= '0;
      dqs_s2 <= '0;
    end else if (ce) begin
      dq_s1  <= dq_i;
      dq_s2  <= dq_s1;
      dqs_s1 <= dqs_i;
      dqs_s2 <= dqs_s1;
    end
  end

  // Command legality against every running timer
  always_comb begin
    wr_idle = 1'b1;
    for (int b = 0; b < 4; b++) begin
      if (wrec_r[b] != '0) begin
        wr_idle = 1'b0;
      end
    end
    run_ok = run_r && (gate_r == '0) && (tog_r == '0);
    legal  = 1'b0;
    unique case (cmd_code)
      LPC_NOP:    legal = 1'b1;
      LPC_ACT:    legal = run_ok && (st_r == LPC_ST_ACTIVE) && (rrd_r == '0)
                          && (bblk_r[cmd_bank] == '0);
      LPC_RD:     legal = run_ok && (((st_r == LPC_ST_ACTIVE) && (wtr_r == '0))
                          || ((st_r == LPC_ST_SRRSEL) && (srr_r == '0)));
      LPC_WR:     legal = run_ok && (st_r == LPC_ST_ACTIVE);
      LPC_PRE:    legal = run_ok && (st_r == LPC_ST_ACTIVE)
                          && (cmd_ap ? wr_idle : (wrec_r[cmd_bank] == '0));
      LPC_REF,
      LPC_MRS,
      LPC_SRSEL,
      LPC_PDE,
      LPC_SRE:    legal = run_ok && (st_r == LPC_ST_ACTIVE) && wr_idle
                          && (wdqs_r == '0);
      LPC_PDX:    legal = run_r && (st_r == LPC_ST_PDOWN) && (ckel_r == '0);
      LPC_SRX:    legal = run_r && (st_r == LPC_ST_SREF) && (ckel_r == '0);
      LPC_CKSTOP: legal = run_ok && (st_r != LPC_ST_SRRSEL) && wr_idle
                          && (wdqs_r == '0) && (pipe_r == '0);
      LPC_CKRUN:  legal = !run_r;
      default:    legal = 1'b0;
    endcase
  end

  assign cmd_ready = ce && legal;
  assign go        = cmd_valid && cmd_ready;
  assign rd_hit    = cfg_cl3 ? pipe_r[`LPC_CL3 + `LPC_SYNC_STAGES]
                             : pipe_r[`LPC_CL2 + `LPC_SYNC_STAGES];

  // Next values of timers, mode and pins
  always_comb begin
    st_nxt    = st_r;
    gate_nxt  = dec(gate_r);
    rrd_nxt   = dec(rrd_r);
    wtr_nxt   = dec(wtr_r);
    srr_nxt   = dec(srr_r);
    ckel_nxt  = dec(ckel_r);
    tog_nxt   = run_r ? dec(tog_r) : tog_r;
    wdqs_nxt  = dec(wdqs_r);
    for (int b = 0; b < 4; b++) begin
      wrec_nxt[b] = dec(wrec_r[b]);
      bblk_nxt[b] = dec(bblk_r[b]);
    end
    refi_nxt  = (refi_r == '0) ? '0 : refi_r - 11'h001;
    due_nxt   = due_r || (refi_r == 11'h001);
    run_nxt   = run_r;
    cke_nxt   = cke_r;
    pin_nxt   = `LPC_PIN_NOP;
    ba_nxt    = ba_r;
    addr_nxt  = addr_r;
    pipe_nxt  = {pipe_r[6:0], 1'b0};
    dqsoe_nxt = (wdqs_r != '0) ? dqsoe_r : 2'h0;
    dqso_nxt  = (wdqs_r > 8'h01) ? ~dqso_r : 2'h0;
    rdv_nxt   = rd_hit;
    rdd_nxt   = rdd_r;
    lane_nxt  = lane_r;
    if (rd_hit) begin
      rdd_nxt  = dq_s2;
      lane_nxt = dqs_s2;
    end
    if (go) begin
      ba_nxt   = cmd_bank;
      addr_nxt = cmd_addr;
      unique case (cmd_code)
        LPC_NOP: begin
        end
        LPC_ACT: begin
          pin_nxt = `LPC_PIN_ACT;
          rrd_nxt = 8'(`LPC_TRRD_CYC);
        end
        LPC_RD: begin
          pin_nxt     = `LPC_PIN_RD;
          pipe_nxt[0] = 1'b1;
          if (st_r == LPC_ST_SRRSEL) begin
            st_nxt   = LPC_ST_ACTIVE;
            gate_nxt = cfg_cl3 ? 8'(`LPC_CL3 + 1) : 8'(`LPC_CL2 + 1);
          end
        end
        LPC_WR: begin
          pin_nxt   = `LPC_PIN_WR;
          addr_nxt  = {cmd_addr[12:11], cmd_ap, cmd_addr[9:0]};
          dqsoe_nxt = 2'h3;
          dqso_nxt  = 2'h0;
          wdqs_nxt  = 8'(`LPC_WBURST_CYC + 1);
          wtr_nxt   = 8'(`LPC_WBURST_CYC + `LPC_TWTR_CYC);
          wrec_nxt[cmd_bank] = 8'(`LPC_WBURST_CYC + `LPC_TWR_CYC);
          if (cmd_ap) begin
            bblk_nxt[cmd_bank] = 8'(`LPC_WBURST_CYC + `LPC_TDAL_CYC);
          end
        end
        LPC_PRE: begin
          pin_nxt  = `LPC_PIN_PRE;
          addr_nxt = {cmd_addr[12:11], cmd_ap, cmd_addr[9:0]};
          for (int b = 0; b < 4; b++) begin
            if (cmd_ap || (cmd_bank == 2'(b))) begin
              bblk_nxt[b] = 8'(`LPC_TRP_CYC);
            end
          end
        end
        LPC_REF: begin
          pin_nxt  = `LPC_PIN_REF;
          gate_nxt = 8'(`LPC_TRFC_CYC);
          refi_nxt = 11'(`LPC_TREFI_CYC);
          due_nxt  = 1'b0;
        end
        LPC_MRS: begin
          pin_nxt  = `LPC_PIN_MRS;
          gate_nxt = 8'(`LPC_TMRD_CYC);
        end
        LPC_SRSEL: begin
          pin_nxt = `LPC_PIN_MRS;
          st_nxt  = LPC_ST_SRRSEL;
          srr_nxt = 8'(`LPC_STATUS_SELECT_TO_READ_CYC);
        end
        LPC_PDE: begin
          cke_nxt  = 1'b0;
          st_nxt   = LPC_ST_PDOWN;
          ckel_nxt = 8'(`LPC_TCKE_CYC);
        end
        LPC_SRE: begin
          pin_nxt  = `LPC_PIN_REF;
          cke_nxt  = 1'b0;
          st_nxt   = LPC_ST_SREF;
          ckel_nxt = 8'(`LPC_TCKE_CYC);
        end
        LPC_PDX: begin
          cke_nxt  = 1'b1;
          st_nxt   = LPC_ST_ACTIVE;
          gate_nxt = 8'(`LPC_TXP_CYC);
        end
        LPC_SRX: begin
          cke_nxt  = 1'b1;
          st_nxt   = LPC_ST_ACTIVE;
          gate_nxt = 8'(`LPC_TXSR_CYC);
          tog_nxt  = 8'(`LPC_XSR_TOGGLES);
          refi_nxt = 11'(`LPC_TREFI_CYC);
          due_nxt  = 1'b0;
        end
        LPC_CKSTOP: run_nxt = 1'b0;
        LPC_CKRUN:  run_nxt = 1'b1;
        default: begin
        end
      endcase
    end
    // Device refreshes itself while in self refresh
    if (st_nxt == LPC_ST_SREF) begin
      refi_nxt = 11'(`LPC_TREFI_CYC);
      due_nxt  = 1'b0;
    end
    fok_nxt = !run_nxt || (st_nxt == LPC_ST_PDOWN) || (st_nxt == LPC_ST_SREF);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r    <= LPC_ST_ACTIVE;
      gate_r  <= '0;
      rrd_r   <= '0;
      wtr_r   <= '0;
      srr_r   <= '0;
      ckel_r  <= '0;
      tog_r   <= '0;
      wdqs_r  <= '0;
      for (int b = 0; b < 4; b++) begin
        wrec_r[b] <= '0;
        bblk_r[b] <= '0;
      end
      refi_r  <= 11'(`LPC_TREFI_CYC);
      due_r   <= 1'b0;
      run_r   <= 1'b1;
      cke_r   <= 1'b1;
      fok_r   <= 1'b0;
      pin_r   <= `LPC_PIN_NOP;
      ba_r    <= '0;
      addr_r  <= '0;
      dqso_r  <= '0;
      dqsoe_r <= '0;
      pipe_r  <= '0;
      rdv_r   <= 1'b0;
      rdd_r   <= '0;
      lane_r  <= '0;
    end else if (ce) begin
      st_r    <= st_nxt;
      gate_r  <= gate_nxt;
      rrd_r   <= rrd_nxt;
      wtr_r   <= wtr_nxt;
      srr_r   <= srr_nxt;
      ckel_r  <= ckel_nxt;
      tog_r   <= tog_nxt;
      wdqs_r  <= wdqs_nxt;
      wrec_r  <= wrec_nxt;
      bblk_r  <= bblk_nxt;
      refi_r  <= refi_nxt;
      due_r   <= due_nxt;
      run_r   <= run_nxt;
      cke_r   <= cke_nxt;
      fok_r   <= fok_nxt;
      pin_r   <= pin_nxt;
      ba_r    <= ba_nxt;
      addr_r  <= addr_nxt;
      dqso_r  <= dqso_nxt;
      dqsoe_r <= dqsoe_nxt;
      pipe_r  <= pipe_nxt;
      rdv_r   <= rdv_nxt;
      rdd_r   <= rdd_nxt;
      lane_r  <= lane_nxt;
    end
  end

  // A held command would repeat if ce stalls a running device clock
  assign ddr_ck_run     = run_r;
  assign ddr_cke        = cke_r;
  assign {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} = pin_r;
  assign ddr_ba         = ba_r;
  assign ddr_addr       = addr_r;
  assign dqs_o          = dqso_r;
  assign dqs_oe         = dqsoe_r;
  assign refresh_due    = due_r;
  assign freq_change_ok = fok_r;
  assign rd_valid       = rdv_r;
  assign rd_data        = rdd_r;
  assign rd_lane_ok     = lane_r;

endmodule : lpc_host
`default_nettype wire

/* hdl/lpc_pkg.sv */
// Types for the low-power DDR command timing controller.
// Assumes lpc_defines.svh supplies every number.
package lpc_pkg;
  typedef enum logic [3:0] {
    LPC_NOP, LPC_ACT, LPC_RD, LPC_WR, LPC_PRE, LPC_REF, LPC_MRS, LPC_SRSEL,
    LPC_PDE, LPC_PDX, LPC_SRE, LPC_SRX, LPC_CKSTOP, LPC_CKRUN
  } lpc_cmd_e;
  typedef enum logic [2:0] {
    LPC_ST_ACTIVE, LPC_ST_PDOWN, LPC_ST_SREF, LPC_ST_SRRSEL
  } lpc_state_e;
  typedef logic [7:0] lpc_cnt_t;
endpackage : lpc_pkg
